// ===== pcg_client_model.sv
// client frame source and receive delimiter counter standing in for the mac
`timescale 1ns/1ps
module pcg_client_model (
    input wire logic pclk,
    output logic [7:0] tx_data,
    output logic tx_enable,
    output logic tx_error_flag,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid
);
    int delim_seen = 0;
    initial begin
        tx_data = 8'h00;
        tx_enable = 1'b0;
        tx_error_flag = 1'b0;
    end
    // preamble with delimiter, payload, four check bytes; error on one chosen beat
    task automatic send_frame(input int n, input int err_at);
        for (int i = 0; i < n + 12; i++) begin
            tx_enable <= 1'b1;
            tx_data <= (i < 7) ? 8'h55 : (i == 7) ? 8'hd5 : 8'(i);
            tx_error_flag <= (i == err_at);
            @(posedge pclk);
        end
        tx_enable <= 1'b0;
        tx_error_flag <= 1'b0;
        tx_data <= ~tx_data; // idle byte changes so a stale copy shows up
    endtask
    // any number of lost preamble bytes is fine, only the delimiter counts
    always @(posedge pclk) begin
        if (rx_valid === 1'b1 && rx_data === 8'hd5) delim_seen <= delim_seen + 1;
    end
endmodule // pcg_client_model

// ===== pcg_client_status.sv
// client byte datapath, receive error coding and link status vector
// Contract
// - transmit bytes under enable pass unchanged as plain data
// - errors are carried through both transmit and receive paths
// - after frame end, error flag with 0x0F means carrier extension
// - error flag raised within frame when decoder sees an error
// - late error in extension drives data 0x1F with error flag
// - false carrier signalled on corrupted start or line noise
// - bit 0 high only when synced and negotiation done if enabled
// - link status mirrored in management status bit 2
// - bit 1 follows synchronization alone
// - bit 7 is partner PHY link in SGMII after negotiation, else low
// - bits 6 to 2 aligned with receive data output
// - bit 2 on config sets, bit 3 on idle sets
// - bit 4 on invalid data inside config or idle set
// - bit 5 on disparity error, bit 6 on unknown code group
// - bits 9:8 remote fault code with negotiation, zero in PHY side
// - bits 11:10 negotiated speed when negotiation enabled
// - bit 12 negotiated duplex, one is full
// - bit 13 sticky remote fault, cleared only by status read
// - bits 15:14 mirror partner ability bits 8:7
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module pcg_client_status #(
    parameter int DATA_W = pcg_pkg::DW
) (
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // client transmit
    input wire logic [DATA_W-1:0] tx_data,
    input wire logic tx_enable,
    input wire logic tx_error_flag,
    // towards encoder
    output logic [DATA_W-1:0] enc_data,
    output logic enc_enable,
    output logic enc_error,
    // from decoder
    input wire logic [DATA_W-1:0] dec_data,
    input wire logic dec_frame,
    input wire logic dec_frame_err,
    input wire logic dec_extend,
    input wire logic dec_extend_err,
    input wire logic dec_bad_start,
    input wire logic dec_config_set,
    input wire logic dec_idle_set,
    input wire logic dec_set_invalid,
    input wire logic dec_disp_err,
    input wire logic dec_not_in_table,
    // link and negotiation state
    input wire logic sync_ok,
    input wire logic an_complete,
    input wire logic phy_link,
    input wire logic [1:0] an_speed,
    input wire logic an_duplex,
    input wire logic remote_fault_evt,
    input wire logic [1:0] remote_fault_code,
    input wire logic [15:0] lp_ability,
    // client receive
    output logic [DATA_W-1:0] rx_data,
    output logic rx_valid,
    output logic rx_error_flag,
    output logic [pcg_pkg::SVW-1:0] status_vector
);
    import pcg_pkg::*;

    logic [2:0] ctrl_r;
    logic rfault_r;
    logic [31:0] prdata_r;
    logic rd_ok_r;
    pcg_rx_e rx_state_r;
    pcg_rx_e rx_state_nxt;
    logic [4:0] rx_ind;
    logic [SVW-1:0] sv_nxt;
    logic [SVW-1:0] sv_r;
    logic an_en;
    logic sgmii;
    logic phy_side;
    logic link_ok;
    logic setup;
    logic access;
    logic addr_hit;
    logic rd_stat;

    pcg_rx_if rx_nxt ();

    assign an_en = ctrl_r[CTRL_AN_EN];
    assign sgmii = ctrl_r[CTRL_SGMII];
    assign phy_side = ctrl_r[CTRL_PHY_SIDE];

    // apb decode; reads are captured in setup so pready can answer at once
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign addr_hit = (paddr == ADDR_CTRL) || (paddr == ADDR_MGMT_STAT)
        || (paddr == ADDR_VECTOR);
    assign rd_stat = access && !pwrite && (paddr == ADDR_MGMT_STAT);
    assign pready = access;
    assign pslverr = access && !rd_ok_r;
    assign prdata = prdata_r;

    // read data register, unmapped addresses read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
            rd_ok_r <= 1'b0;
        end else if (setup) begin
            rd_ok_r <= addr_hit;
            prdata_r <= 32'h0000_0000;
            if (paddr == ADDR_CTRL) begin
                prdata_r[2:0] <= ctrl_r;
            end else if (paddr == ADDR_MGMT_STAT) begin
                prdata_r[MST_LINK] <= sv_r[SV_LINK];
                prdata_r[MST_RFAULT] <= rfault_r;
            end else if (paddr == ADDR_VECTOR) begin
                prdata_r[SVW-1:0] <= sv_r;
            end
        end
    end

    // control register: negotiation enable, sgmii mode, phy side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_RESET;
        end else if (access && pwrite && (paddr == ADDR_CTRL)) begin
            ctrl_r <= pwdata[2:0];
        end
    end

    // sticky remote fault; a new fault wins over the clearing read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rfault_r <= 1'b0;
        end else if (remote_fault_evt) begin
            rfault_r <= 1'b1;
        end else if (rd_stat) begin
            rfault_r <= 1'b0;
        end
    end

    // transmit path: bytes are never parsed, the error flag rides along
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enc_data <= '0;
            enc_enable <= 1'b0;
            enc_error <= 1'b0;
        end else begin
            enc_data <= tx_data;
            enc_enable <= tx_enable;
            enc_error <= tx_error_flag;
        end
    end

    // receive classification; extension may only follow a frame
    always_comb begin
        rx_state_nxt = rx_state_r;
        unique case (rx_state_r)
            RX_IDLE: begin
                if (dec_frame) begin
                    rx_state_nxt = RX_FRAME;
                end else if (dec_bad_start) begin
                    rx_state_nxt = RX_FALSE;
                end
            end
            RX_FRAME: begin
                if (!dec_frame) begin
                    rx_state_nxt = dec_extend ? RX_EXTEND : RX_IDLE;
                end
            end
            RX_EXTEND: begin
                if (dec_frame) begin
                    rx_state_nxt = RX_FRAME;
                end else if (!dec_extend) begin
                    rx_state_nxt = RX_IDLE;
                end
            end
            RX_FALSE: begin
                if (dec_frame) begin
                    rx_state_nxt = RX_FRAME;
                end else if (!dec_bad_start) begin
                    rx_state_nxt = RX_IDLE;
                end
            end
        endcase
    end

    // receive state; a new frame always wins over extension or false carrier
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_r <= RX_IDLE;
        end else begin
            rx_state_r <= rx_state_nxt;
        end
    end

    // receive byte coding for the cycle being classified
    always_comb begin
        rx_nxt.data = CODE_NONE;
        rx_nxt.valid = 1'b0;
        rx_nxt.err = 1'b0;
        unique case (rx_state_nxt)
            RX_FRAME: begin
                rx_nxt.data = dec_data;
                rx_nxt.valid = 1'b1;
                rx_nxt.err = dec_frame_err;
            end
            RX_EXTEND: begin
                rx_nxt.err = 1'b1;
                rx_nxt.data = dec_extend_err ? CODE_LATE_ERR : CODE_CARR_EXT;
            end
            RX_FALSE: begin
                rx_nxt.err = 1'b1;
                rx_nxt.data = CODE_FALSE_CARR;
            end
            RX_IDLE: begin
                rx_nxt.data = CODE_NONE;
            end
        endcase
    end

    // code-group indicators go through the same output stage as the data
    assign rx_nxt.ind = {dec_not_in_table, dec_disp_err,
        dec_set_invalid && (dec_config_set || dec_idle_set),
        dec_idle_set, dec_config_set};

    pcg_rx_stage u_rx_stage (
        .pclk(pclk),
        .presetn(presetn),
        .nxt(rx_nxt.dst),
        .rx_data(rx_data),
        .rx_valid(rx_valid),
        .rx_error_flag(rx_error_flag),
        .rx_ind(rx_ind)
    );

    // link is only good once negotiation has finished, when it is enabled
    assign link_ok = sync_ok && (!an_en || an_complete);

    // status vector assembly
    always_comb begin
        sv_nxt = '0;
        sv_nxt[SV_LINK] = link_ok;
        sv_nxt[SV_SYNC] = sync_ok;
        sv_nxt[SV_PHY_LINK] = sgmii && an_complete && phy_link;
        if (an_en && !(sgmii && phy_side)) begin
            sv_nxt[SV_RF_HI:SV_RF_LO] = remote_fault_code;
        end else begin
            sv_nxt[SV_RF_HI:SV_RF_LO] = RF_NONE;
        end
        sv_nxt[SV_SPD_HI:SV_SPD_LO] = an_en ? an_speed : SPD_NONE;
        sv_nxt[SV_DUPLEX] = an_duplex;
        sv_nxt[SV_RFAULT] = rfault_r;
        sv_nxt[SV_PAUSE_HI:SV_PAUSE_LO] = lp_ability[LP_PAUSE_HI:LP_PAUSE_LO];
    end

    // registered fields, one cycle behind their sources
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sv_r <= '0;
        end else begin
            sv_r <= sv_nxt;
        end
    end

    // indicator bits come straight from the output stage, not sv_r
    always_comb begin
        status_vector = sv_r;
        status_vector[SV_IND_HI:SV_IND_LO] = rx_ind;
    end

    tx_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> (enc_data == $past(tx_data)) && (enc_enable == $past(tx_enable))
            && (enc_error == $past(tx_error_flag)))
        else $error("transmit byte or qualifiers altered");

    ext_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_state_r == RX_FRAME && !dec_frame && dec_extend && !dec_extend_err)
            |=> rx_error_flag && !rx_valid && (rx_data == CODE_CARR_EXT))
        else $error("carrier extension not coded as 0x0f");

    late_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_state_r == RX_EXTEND && dec_extend && dec_extend_err && !dec_frame)
            |=> rx_error_flag && (rx_data == CODE_LATE_ERR))
        else $error("late error not coded as 0x1f");

    false_carr_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_state_r == RX_IDLE && !dec_frame && dec_bad_start)
            |=> rx_error_flag && !rx_valid && (rx_data == CODE_FALSE_CARR))
        else $error("false carrier coding wrong");

    frame_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        dec_frame |=> rx_valid && (rx_error_flag == $past(dec_frame_err)))
        else $error("frame error not flagged");

    link_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!sync_ok || (an_en && !an_complete)) |=> !status_vector[SV_LINK])
        else $error("link reported without sync or negotiation");

    sync_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> status_vector[SV_SYNC] == $past(sync_ok))
        else $error("sync bit does not follow sync state");

    phy_link_a: assert property (@(posedge pclk) disable iff (!presetn)
        !sgmii |=> !status_vector[SV_PHY_LINK])
        else $error("phy link bit high outside sgmii");

    rfault_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rfault_r && !rd_stat) |=> rfault_r)
        else $error("remote fault cleared without status read");

    pause_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> status_vector[SV_PAUSE_HI:SV_PAUSE_LO]
            == $past(lp_ability[LP_PAUSE_HI:LP_PAUSE_LO]))
        else $error("pause bits do not mirror partner ability");

    speed_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        !an_en |=> status_vector[SV_SPD_HI:SV_SPD_LO] == SPD_NONE)
        else $error("speed reported with negotiation disabled");

    // indicators at the status port follow the decoder flags one cycle later
    ind_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> status_vector[SV_IND_HI:SV_IND_LO] == $past({dec_not_in_table,
            dec_disp_err, dec_set_invalid && (dec_config_set || dec_idle_set),
            dec_idle_set, dec_config_set}))
        else $error("code-group indicators do not follow decoder");

    duplex_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> status_vector[SV_DUPLEX] == $past(an_duplex))
        else $error("duplex bit does not follow negotiation");

    rf_phy_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sgmii && phy_side) |=> status_vector[SV_RF_HI:SV_RF_LO] == RF_NONE)
        else $error("remote fault code shown on phy side");

    link_mirror_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && (paddr == ADDR_MGMT_STAT)) |=> prdata[MST_LINK] == $past(sv_r[SV_LINK]))
        else $error("management link bit does not mirror status");

    fault_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        remote_fault_evt |=> rfault_r)
        else $error("remote fault event not latched");
endmodule // pcg_client_status

// ===== pcg_client_status_tb.sv
// self-checking bench for the client datapath and status block
`timescale 1ns/1ps
module pcg_client_status_tb;
    import pcg_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, e, enc_enable, enc_error, rx_valid, rx_error_flag;
    logic [7:0] tx_data, enc_data, dec_data = 8'h00, rx_data;
    logic tx_enable, tx_error_flag, sync_ok = 0, an_complete = 0, phy_link = 0;
    logic an_duplex = 0, remote_fault_evt = 0;
    logic f = 0, fe = 0, ex = 0, xe = 0, bs = 0;
    logic [4:0] ind = 5'h00;
    logic [1:0] an_speed = 2'h0, remote_fault_code = 2'h0;
    logic [15:0] lp_ability = 16'h0, status_vector, x;
    logic [15:0] tx_q = 16'h0;
    int err_total = 0, samples_checked = 0;

    pcg_client_status pcg_client_status_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_data(tx_data),
        .tx_enable(tx_enable), .tx_error_flag(tx_error_flag), .enc_data(enc_data),
        .enc_enable(enc_enable), .enc_error(enc_error), .dec_data(dec_data),
        .dec_frame(f), .dec_frame_err(fe), .dec_extend(ex), .dec_extend_err(xe),
        .dec_bad_start(bs), .dec_config_set(ind[0]), .dec_idle_set(ind[1]),
        .dec_set_invalid(ind[2]), .dec_disp_err(ind[3]), .dec_not_in_table(ind[4]),
        .sync_ok(sync_ok), .an_complete(an_complete), .phy_link(phy_link),
        .an_speed(an_speed), .an_duplex(an_duplex), .remote_fault_evt(remote_fault_evt),
        .remote_fault_code(remote_fault_code), .lp_ability(lp_ability),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_error_flag(rx_error_flag),
        .status_vector(status_vector));
    pcg_client_model pcg_client_model_i (.pclk(pclk), .tx_data(tx_data),
        .tx_enable(tx_enable), .tx_error_flag(tx_error_flag), .rx_data(rx_data),
        .rx_valid(rx_valid));

    initial forever #5 pclk = ~pclk;
    // transmit inputs seen at each edge, for the one-cycle copy check
    always @(posedge pclk) tx_q <= {6'h0, tx_enable, tx_error_flag, tx_data};

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string m);
        chk16(got[31:16], exp[31:16], m);
        chk16(got[15:0], exp[15:0], m);
    endtask
    // one apb transfer; the wait on pready is bounded by the watchdog only
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic t_apb;
        apb(0, ADDR_CTRL, 0);
        chk32(rd, 32'h1, "ctrl reset");
        apb(1, ADDR_CTRL, 32'h6);
        apb(0, ADDR_CTRL, 0);
        chk32({rd[31:1], e}, 32'h6, "ctrl rw");
        apb(0, 12'h00c, 0);
        chk32({rd[30:0], e}, 32'h1, "unmapped");
        apb(1, ADDR_CTRL, 32'h1);
        $display("test apb done");
    endtask
    task automatic t_tx;
        @(posedge pclk);
        fork
            pcg_client_model_i.send_frame(6, 9);
            repeat (20) begin
                @(negedge pclk);
                chk16({6'h0, enc_enable, enc_error, enc_data}, tx_q, "tx copy");
            end
        join
        $display("test tx done");
    endtask
    // called at an edge; each byte stands one cycle, judged at the next falling edge
    task automatic rx_step(input logic [4:0] c, input logic [7:0] d, input logic [9:0] ex_o,
        input logic [4:0] ei);
        {f, fe, ex, xe, bs} <= c;
        dec_data <= d;
        @(posedge pclk);
        fork
            begin
                @(negedge pclk);
                chk16({6'h0, rx_valid, rx_error_flag, rx_data}, {6'h0, ex_o}, "rx");
                chk16({11'h0, status_vector[SV_IND_HI:SV_IND_LO]}, {11'h0, ei}, "ind");
            end
        join_none
    endtask
    task automatic t_rx;
        @(posedge pclk);
        rx_step(5'b10000, 8'h55, {2'b10, 8'h55}, 5'h00);
        rx_step(5'b10000, 8'hd5, {2'b10, 8'hd5}, 5'h00);
        rx_step(5'b11000, 8'h33, {2'b11, 8'h33}, 5'h00);
        rx_step(5'b00100, 8'h00, {2'b01, CODE_CARR_EXT}, 5'h00);
        rx_step(5'b00110, 8'h00, {2'b01, CODE_LATE_ERR}, 5'h00);
        rx_step(5'b00000, 8'h00, 10'h0, 5'h00);
        rx_step(5'b00001, 8'h00, {2'b01, CODE_FALSE_CARR}, 5'h00);
        rx_step(5'b00000, 8'h00, 10'h0, 5'h00);
        @(posedge pclk);
        chk32(pcg_client_model_i.delim_seen, 32'h1, "delimiter");
        $display("test rx done");
    endtask
    task automatic t_ind;
        logic [4:0] tab [5] = '{5'h01, 5'h02, 5'h06, 5'h08, 5'h10};
        for (int i = 0; i < 5; i++) begin
            ind <= tab[i];
            rx_step(5'b10000, 8'(i + 1), {2'b10, 8'(i + 1)}, tab[i]);
        end
        ind <= 5'h00;
        rx_step(5'b00000, 8'h00, 10'h0, 5'h00);
        @(posedge pclk);
        $display("test indicators done");
    endtask
    task automatic t_status;
        for (int i = 0; i < 16; i++) begin
            apb(1, ADDR_CTRL, 32'(i[2:0]));
            sync_ok <= i[0] ^ i[3];
            an_complete <= i[1] | i[3];
            phy_link <= ~i[2];
            an_speed <= i[1:0];
            an_duplex <= i[2];
            remote_fault_code <= i[3:2] + 2'h1;
            lp_ability <= {7'h0, i[1:0], 7'h0};
            repeat (2) @(posedge pclk);
            #1;
            x = '0;
            x[0] = (i[0] ^ i[3]) & (!i[0] | i[1] | i[3]);
            x[1] = i[0] ^ i[3];
            x[7] = i[1] & (i[1] | i[3]) & ~i[2];
            x[9:8] = (i[0] && !(i[1] && i[2])) ? i[3:2] + 2'h1 : RF_NONE;
            x[11:10] = i[0] ? i[1:0] : SPD_NONE;
            x[12] = i[2];
            x[15:14] = i[1:0];
            chk16(status_vector, x, "status");
            apb(0, ADDR_MGMT_STAT, 0);
            chk16({15'h0, rd[MST_LINK]}, {15'h0, x[0]}, "link mirror");
        end
        apb(1, ADDR_CTRL, 32'h1);
        $display("test status done");
    endtask
    task automatic t_fault;
        @(posedge pclk);
        remote_fault_evt <= 1'b1;
        @(posedge pclk);
        remote_fault_evt <= 1'b0;
        repeat (3) @(posedge pclk);
        chk16({15'h0, status_vector[SV_RFAULT]}, 16'h1, "fault sticky");
        apb(0, ADDR_MGMT_STAT, 0);
        chk16({15'h0, rd[MST_RFAULT]}, 16'h1, "fault read");
        repeat (2) @(posedge pclk);
        chk16({15'h0, status_vector[SV_RFAULT]}, 16'h0, "fault clear");
        // event held through the clearing read: the set must win
        remote_fault_evt <= 1'b1;
        apb(0, ADDR_MGMT_STAT, 0);
        remote_fault_evt <= 1'b0;
        repeat (2) @(posedge pclk);
        chk16({15'h0, status_vector[SV_RFAULT]}, 16'h1, "fault set wins");
        $display("test fault done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #200us;
        err_total++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_apb();
        t_tx();
        t_rx();
        t_ind();
        t_status();
        t_fault();
        close_out();
    end
endmodule // pcg_client_status_tb

// ===== pcg_pkg.sv
// shared constants, codes and offsets for the client datapath and status block
package pcg_pkg;
    localparam int DW = 8;
    localparam int SVW = 16;
    // receive codes driven with valid low, all but CODE_NONE with the error flag
    localparam logic [7:0] CODE_CARR_EXT = 8'h0f;
    localparam logic [7:0] CODE_LATE_ERR = 8'h1f;
    localparam logic [7:0] CODE_FALSE_CARR = 8'h0e;
    localparam logic [7:0] CODE_NONE = 8'h00;
    // register byte offsets
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_MGMT_STAT = 12'h004;
    localparam logic [11:0] ADDR_VECTOR = 12'h008;
    // control register fields
    localparam int CTRL_AN_EN = 0;
    localparam int CTRL_SGMII = 1;
    localparam int CTRL_PHY_SIDE = 2;
    localparam logic [2:0] CTRL_RESET = 3'h1;
    // management status fields
    localparam int MST_LINK = 2;
    localparam int MST_RFAULT = 4;
    // status vector fields
    localparam int SV_LINK = 0;
    localparam int SV_SYNC = 1;
    localparam int SV_IND_LO = 2;
    localparam int SV_IND_HI = 6;
    localparam int SV_PHY_LINK = 7;
    localparam int SV_RF_LO = 8;
    localparam int SV_RF_HI = 9;
    localparam int SV_SPD_LO = 10;
    localparam int SV_SPD_HI = 11;
    localparam int SV_DUPLEX = 12;
    localparam int SV_RFAULT = 13;
    localparam int SV_PAUSE_LO = 14;
    localparam int SV_PAUSE_HI = 15;
    // partner base ability fields
    localparam int LP_PAUSE_LO = 7;
    localparam int LP_PAUSE_HI = 8;
    localparam logic [1:0] RF_NONE = 2'h0;
    localparam logic [1:0] SPD_NONE = 2'h0;
    // receive classification, gray along idle-frame-extend-false
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_FRAME = 2'b01,
        RX_EXTEND = 2'b11,
        RX_FALSE = 2'b10
    } pcg_rx_e;
endpackage

// ===== pcg_rx_if.sv
// next-cycle receive outputs handed from classifier to output stage
`timescale 1ns/1ps
interface pcg_rx_if;
    logic [pcg_pkg::DW-1:0] data;
    logic valid;
    logic err;
    logic [4:0] ind;
    modport src (output data, valid, err, ind);
    modport dst (input data, valid, err, ind);
endinterface

// ===== pcg_rx_stage.sv
// output register stage for receive bus and code-group indicators
`timescale 1ns/1ps
module pcg_rx_stage (
    input wire logic pclk,
    input wire logic presetn,
    pcg_rx_if.dst nxt,
    output logic [pcg_pkg::DW-1:0] rx_data,
    output logic rx_valid,
    output logic rx_error_flag,
    output logic [4:0] rx_ind
);
    import pcg_pkg::*;

    // one common stage keeps indicators aligned with the data they describe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data <= CODE_NONE;
            rx_valid <= 1'b0;
            rx_error_flag <= 1'b0;
            rx_ind <= 5'h00;
        end else begin
            rx_data <= nxt.data;
            rx_valid <= nxt.valid;
            rx_error_flag <= nxt.err;
            rx_ind <= nxt.ind;
        end
    end

    // indicators move in lock step with receive data
    ind_align_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> (rx_ind == $past(nxt.ind)) && (rx_data == $past(nxt.data)))
        else $error("indicators out of step with receive data");
endmodule // pcg_rx_stage
